// ### phy_mode_special_pkg.sv
/*
 * constants for the per-phy mode control/status and special setup registers
 * assumes a 125 MHz system clock and a 5-bit management register index
 */
// Overview of operation
// - energy-detect sleep only while control bit 13 is set; resets to zero
// - control bit 6 picks primary (0) or alternate (1) interrupt scheme; resets zero
// - energy flag drops after 256 ms without energy, 1500 ms with autonegotiation
// - energy flag set by hardware reset; soft reset sets it when autonegotiation is on or the fiber strap is low (copper)
// - fiber bit default comes from each phy's own fiber strap
// - setting 000 is 10 Mb/s half, 001 is 10 Mb/s full, no autonegotiation
// - 010 is 100 half carrier on tx and rx; 011 is 100 full carrier rx
// - operating setting bits 7:5 default 100b copper, 011b fiber
// - address bits 4:0 select management address and seed the scrambler
// - soft reset keeps kept fields; device phy reset restores their defaults
// - 100 advertises 100 full with autoneg, 110 power down, 111 all, 101 reserved
package phy_mode_special_pkg;

    localparam int unsigned CLK_KHZ           = 125000;
    localparam int unsigned QUIET_MS          = 256;
    localparam int unsigned QUIET_AN_MS       = 1500;
    localparam int unsigned QUIET_CYCLES      = QUIET_MS * CLK_KHZ;
    localparam int unsigned QUIET_AN_CYCLES   = QUIET_AN_MS * CLK_KHZ;

    localparam logic [4:0]  POWER_IRQ_INDEX   = 5'h11;
    localparam logic [4:0]  SPECIAL_INDEX     = 5'h12;

    localparam int unsigned SLEEP_EN_BIT      = 13;
    localparam int unsigned ALT_IRQ_BIT       = 6;
    localparam int unsigned ENERGY_BIT        = 1;
    localparam int unsigned FIBER_BIT         = 10;
    localparam int unsigned SETTING_LSB       = 5;
    localparam int unsigned ADDRESS_LSB       = 0;

    localparam logic        SLEEP_EN_RESET    = 1'b0;
    localparam logic        ALT_IRQ_RESET     = 1'b0;
    localparam logic        ENERGY_RESET      = 1'b1;

    typedef enum logic [2:0]
    {
        SET_10_HALF   = 3'h0,
        SET_10_FULL   = 3'h1,
        SET_100_HALF  = 3'h2,
        SET_100_FULL  = 3'h3,
        SET_AN_100    = 3'h4,
        SET_RESERVED  = 3'h5,
        SET_POWERDOWN = 3'h6,
        SET_AN_ALL    = 3'h7
    } op_setting_type;

    localparam op_setting_type SETTING_COPPER_RESET = SET_AN_100;
    localparam op_setting_type SETTING_FIBER_RESET  = SET_100_FULL;

endpackage : phy_mode_special_pkg

// ### phy_mode_special_regs.sv
/*
 * mode control/status and special setup registers for two integrated phys
 * assumes the management frame decoder delivers one-cycle read/write strobes
 * with a phy select and register index, and reset requests as pulses
 */
`timescale 1ns/1ps
`default_nettype none

module phy_mode_special_regs
#(
    parameter int unsigned QUIET_LIMIT    = phy_mode_special_pkg::QUIET_CYCLES,
    parameter int unsigned QUIET_AN_LIMIT = phy_mode_special_pkg::QUIET_AN_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        device_reset_control,
    input  wire logic [1:0]  phy_soft_reset_bit,
    input  wire logic        fiber_strap_first,
    input  wire logic        fiber_strap_second,
    input  wire logic [4:0]  address_strap_first,
    input  wire logic [4:0]  address_strap_second,
    input  wire logic [1:0]  line_energy_seen,
    input  wire logic        mgmt_phy_sel,
    input  wire logic [4:0]  mgmt_index,
    input  wire logic        mgmt_write,
    input  wire logic        mgmt_read,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic      [1:0]  energy_detect_sleep,
    output logic      [1:0]  alternate_irq_select,
    output logic      [1:0]  line_energy_present,
    output logic      [1:0]  fiber_operation,
    output logic      [1:0]  speed_100,
    output logic      [1:0]  full_duplex,
    output logic      [1:0]  autoneg_enable,
    output logic      [1:0]  advertise_all,
    output logic      [1:0]  phy_power_down,
    output logic      [1:0]  carrier_on_transmit,
    output logic [1:0][4:0]  phy_station_address
);
    import phy_mode_special_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // per-phy register state

    logic      [1:0]       sleep_en_q,  sleep_en_d;
    logic      [1:0]       alt_irq_q,   alt_irq_d;
    logic      [1:0]       energy_q,    energy_d;
    logic      [1:0]       fiber_q,     fiber_d;
    logic [1:0][2:0]       setting_q,   setting_d;
    logic [1:0][4:0]       address_q,   address_d;
    logic [1:0][27:0]      quiet_q,     quiet_d;
    logic      [15:0]      rdata_d;
    logic      [1:0]       strap_fiber;
    logic [1:0][4:0]       strap_addr;
    logic      [1:0]       an_on;
    logic                  phy_reset;
    // write strobes decoded per phy
    logic      [1:0]       write_power;
    logic      [1:0]       write_special;

    assign strap_fiber = {fiber_strap_second, fiber_strap_first};
    assign strap_addr  = {address_strap_second, address_strap_first};

    ////////////////////////////////////////////////////////////////////////
    // shared decode of strobes, resets and the autonegotiation state

    // hardware reset and the device phy reset act alike on every field,
    // the kept ones included; only the read data register tells them apart
    assign phy_reset = srst || device_reset_control;

    always_comb
    begin
        write_power   = '0;
        write_special = '0;
        an_on         = '0;
        for (int p = 0; p < 2; p++)
        begin
            write_power[p]   = mgmt_write
                            && (mgmt_phy_sel == p[0])
                            && (mgmt_index == POWER_IRQ_INDEX);
            write_special[p] = mgmt_write
                            && (mgmt_phy_sel == p[0])
                            && (mgmt_index == SPECIAL_INDEX);
            // only settings 100 and 111 run autonegotiation
            an_on[p]         = (setting_q[p] == SET_AN_100)
                            || (setting_q[p] == SET_AN_ALL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power and interrupt control bits

    always_comb
    begin
        sleep_en_d = sleep_en_q;
        alt_irq_d  = alt_irq_q;
        for (int p = 0; p < 2; p++)
        begin
            if (write_power[p])
            begin
                sleep_en_d[p] = mgmt_wdata[SLEEP_EN_BIT];
                alt_irq_d[p]  = mgmt_wdata[ALT_IRQ_BIT];
            end
            // a reset beats a write in the same cycle to any bit that it resets
            if (phy_reset)
            begin
                sleep_en_d[p] = SLEEP_EN_RESET;
                alt_irq_d[p]  = ALT_IRQ_RESET;
            end
            else if (phy_soft_reset_bit[p])
            begin
                // sleep enable is not kept, the interrupt scheme is
                sleep_en_d[p] = SLEEP_EN_RESET;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        sleep_en_q <= sleep_en_d;
        alt_irq_q  <= alt_irq_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // line energy flag and its quiet timer

    // the timer holds one below its limit instead of wrapping; 28 bits cover the
    // longer interval at 125 MHz, so larger limits need a wider timer
    always_comb
    begin
        energy_d = energy_q;
        quiet_d  = quiet_q;
        for (int p = 0; p < 2; p++)
        begin
            // any energy this cycle sets the flag and restarts the count
            if (line_energy_seen[p])
            begin
                energy_d[p] = 1'b1;
                quiet_d[p]  = '0;
            end
            else if (an_on[p] ? (quiet_q[p] >= 28'(QUIET_AN_LIMIT - 1))
                              : (quiet_q[p] >= 28'(QUIET_LIMIT - 1)))
            begin
                energy_d[p] = 1'b0;
            end
            else
            begin
                quiet_d[p] = quiet_q[p] + 28'h0000001;
            end
            if (phy_reset)
            begin
                energy_d[p] = ENERGY_RESET;
                quiet_d[p]  = '0;
            end
            else if (phy_soft_reset_bit[p])
            begin
                // a copper strap or autonegotiation left on sets the energy flag again on soft reset
                quiet_d[p] = '0;
                if (an_on[p] || !strap_fiber[p])
                begin
                    energy_d[p] = ENERGY_RESET;
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        energy_q <= energy_d;
        quiet_q  <= quiet_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // special setup fields: fiber flag, operating setting, station address

    always_comb
    begin
        fiber_d   = fiber_q;
        setting_d = setting_q;
        address_d = address_q;
        for (int p = 0; p < 2; p++)
        begin
            if (write_special[p])
            begin
                // fiber bit is strap-owned, its write data is dropped
                setting_d[p] = mgmt_wdata[SETTING_LSB +: 3];
                address_d[p] = mgmt_wdata[ADDRESS_LSB +: 5];
            end
            // a soft reset leaves all three fields alone
            if (phy_reset)
            begin
                fiber_d[p]   = strap_fiber[p];
                setting_d[p] = strap_fiber[p] ? SETTING_FIBER_RESET
                                              : SETTING_COPPER_RESET;
                address_d[p] = strap_addr[p];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        fiber_q   <= fiber_d;
        setting_q <= setting_d;
        address_q <= address_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, held until the next read

    always_comb
    begin
        rdata_d = mgmt_rdata;
        if (mgmt_read)
        begin
            rdata_d = 16'h0000;
            // one read register serves both phys; the select picks the source
            unique case (mgmt_index)
                POWER_IRQ_INDEX:
                begin
                    rdata_d[SLEEP_EN_BIT] = sleep_en_q[mgmt_phy_sel];
                    rdata_d[ALT_IRQ_BIT]  = alt_irq_q[mgmt_phy_sel];
                    rdata_d[ENERGY_BIT]   = energy_q[mgmt_phy_sel];
                end
                SPECIAL_INDEX:
                begin
                    rdata_d[FIBER_BIT]        = fiber_q[mgmt_phy_sel];
                    rdata_d[SETTING_LSB +: 3] = setting_q[mgmt_phy_sel];
                    rdata_d[ADDRESS_LSB +: 5] = address_q[mgmt_phy_sel];
                end
                default:
                begin
                    // unmapped indexes read as zero
                    rdata_d = 16'h0000;
                end
            endcase
        end
        // only the hardware reset clears the last read word
        if (srst)
        begin
            rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        mgmt_rdata <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded operating controls

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            energy_detect_sleep[p]  = sleep_en_q[p] && !energy_q[p];
            alternate_irq_select[p] = alt_irq_q[p];
            line_energy_present[p]  = energy_q[p];
            fiber_operation[p]      = fiber_q[p];
            phy_station_address[p]  = address_q[p];
            speed_100[p]            = 1'b0;
            full_duplex[p]          = 1'b0;
            autoneg_enable[p]       = 1'b0;
            advertise_all[p]        = 1'b0;
            phy_power_down[p]       = 1'b0;
            carrier_on_transmit[p]  = 1'b0;
            // every control starts low, so the reserved setting 101
            // decodes like 000, 10 Mb/s half, instead of holding a stale mode
            unique case (op_setting_type'(setting_q[p]))
                SET_10_HALF:   ;
                SET_10_FULL:   full_duplex[p] = 1'b1;
                SET_100_HALF:
                begin
                    speed_100[p]           = 1'b1;
                    carrier_on_transmit[p] = 1'b1;
                end
                SET_100_FULL:
                begin
                    speed_100[p]   = 1'b1;
                    full_duplex[p] = 1'b1;
                end
                SET_AN_100:
                begin
                    speed_100[p]      = 1'b1;
                    full_duplex[p]    = 1'b1;
                    autoneg_enable[p] = 1'b1;
                end
                SET_RESERVED:  ;
                SET_POWERDOWN: phy_power_down[p] = 1'b1;
                SET_AN_ALL:
                begin
                    autoneg_enable[p] = 1'b1;
                    advertise_all[p]  = 1'b1;
                end
            endcase
        end
    end

endmodule : phy_mode_special_regs

`default_nettype wire

// ### phy_mode_special_regs_assertions.sv
/* port checker for phy_mode_special_regs, phy 0 side; device reset energy, interrupt and sleep values and fiber hold checked on both phys
   assumes it is bound onto the design top in the clk_sys domain */
`timescale 1ns/1ps
`default_nettype none
module phy_mode_special_regs_assertions
#(
    parameter int unsigned QUIET_LIMIT    = 20,
    parameter int unsigned QUIET_AN_LIMIT = 50
)
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        device_reset_control,
    input wire logic [1:0]  phy_soft_reset_bit,
    input wire logic        fiber_strap_first,
    input wire logic [1:0]  line_energy_seen,
    input wire logic        mgmt_phy_sel,
    input wire logic [4:0]  mgmt_index,
    input wire logic        mgmt_write,
    input wire logic        mgmt_read,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic [1:0]  energy_detect_sleep,
    input wire logic [1:0]  alternate_irq_select,
    input wire logic [1:0]  line_energy_present,
    input wire logic [1:0]  fiber_operation,
    input wire logic [1:0]  speed_100,
    input wire logic [1:0]  full_duplex,
    input wire logic [1:0]  autoneg_enable,
    input wire logic [1:0]  carrier_on_transmit
);
////////////////////////////////////////////////////////////////////////////
int quiet_q;
int quiet_d;
logic wr0;
logic sleep_m;
assign wr0 = mgmt_write && !mgmt_phy_sel && !device_reset_control;
always_comb
begin
    quiet_d = quiet_q + 1;
    if (line_energy_seen[0] || phy_soft_reset_bit[0] || device_reset_control)
        quiet_d = 0;
end
always_ff @(posedge clk_sys)
    quiet_q <= srst ? 0 : quiet_d;
// sleep enable as the station set it; any reset of phy 0 clears it
always_ff @(posedge clk_sys)
    if (srst || device_reset_control || phy_soft_reset_bit[0])
        sleep_m <= 1'b0;
    else if (wr0 && mgmt_index == 5'h11)
        sleep_m <= mgmt_wdata[13];
default clocking cb @(posedge clk_sys); endclocking
default disable iff (srst);
sequence s_sleep_on;
    wr0 && mgmt_index == 5'h11 && mgmt_wdata[13] && !phy_soft_reset_bit[0];
endsequence
a_sleep_needs_quiet: assert property (
    energy_detect_sleep[0] == (sleep_m && !line_energy_present[0]))
    else $error("sleep");
a_sleep_follows: assert property (
    s_sleep_on ##1 !line_energy_present[0] |-> energy_detect_sleep[0])
    else $error("sleep enable");
a_alt_from_write: assert property (
    wr0 && mgmt_index == 5'h11 |=> alternate_irq_select[0] ==
    $past(mgmt_wdata[6])) else $error("alt irq");
a_phy_reset_vals: assert property (
    device_reset_control |=> line_energy_present == 2'h3 &&
    alternate_irq_select == 2'h0 && energy_detect_sleep == 2'h0 &&
    fiber_operation[0] == $past(fiber_strap_first)) else $error("reset");
a_fiber_kept: assert property (
    wr0 |=> $stable(fiber_operation)) else $error("fiber");
a_mode_100_half: assert property (
    wr0 && mgmt_index == 5'h12 && mgmt_wdata[7:5] == 3'h2 |=>
    carrier_on_transmit[0] && speed_100[0] && !full_duplex[0])
    else $error("mode 010");
a_mode_10_full: assert property (
    wr0 && mgmt_index == 5'h12 && mgmt_wdata[7:5] == 3'h1 |=>
    full_duplex[0] && !speed_100[0] && !autoneg_enable[0])
    else $error("mode 001");
a_unmapped_zero: assert property (
    mgmt_read && mgmt_index != 5'h11 && mgmt_index != 5'h12 |=>
    mgmt_rdata == 16'h0000) else $error("unmapped");
a_energy_rises: assert property (
    line_energy_seen[0] |=> line_energy_present[0]) else $error("energy");
a_quiet_floor: assert property (
    $fell(line_energy_present[0]) |-> quiet_q + 2 >= QUIET_LIMIT)
    else $error("early drop");
a_quiet_ceiling: assert property (
    quiet_q > QUIET_AN_LIMIT + 2 |-> !line_energy_present[0])
    else $error("late drop");
endmodule : phy_mode_special_regs_assertions
bind phy_mode_special_regs phy_mode_special_regs_assertions
#(.QUIET_LIMIT(QUIET_LIMIT), .QUIET_AN_LIMIT(QUIET_AN_LIMIT)) u_chk
(
    .clk_sys(clk_sys), .srst(srst), .device_reset_control(device_reset_control),
    .phy_soft_reset_bit(phy_soft_reset_bit), .mgmt_rdata(mgmt_rdata),
    .fiber_strap_first(fiber_strap_first), .line_energy_seen(line_energy_seen),
    .mgmt_phy_sel(mgmt_phy_sel), .mgmt_index(mgmt_index), .mgmt_read(mgmt_read),
    .mgmt_write(mgmt_write), .mgmt_wdata(mgmt_wdata), .speed_100(speed_100),
    .energy_detect_sleep(energy_detect_sleep), .full_duplex(full_duplex),
    .alternate_irq_select(alternate_irq_select), .autoneg_enable(autoneg_enable),
    .line_energy_present(line_energy_present), .fiber_operation(fiber_operation),
    .carrier_on_transmit(carrier_on_transmit)
);
`default_nettype wire

// ### mgmt_station.sv
/* management station model driving the register strobe port
   assumes clk_sys from the bench and one request at a time */
`timescale 1ns/1ps
`default_nettype none
module mgmt_station
(
    input  wire logic        clk_sys,
    input  wire logic [15:0] mgmt_rdata,
    output var  logic        mgmt_phy_sel,
    output var  logic [4:0]  mgmt_index,
    output var  logic        mgmt_write,
    output var  logic        mgmt_read,
    output var  logic [15:0] mgmt_wdata
);
////////////////////////////////////////////////////////////////////////////
initial
begin
    {mgmt_phy_sel, mgmt_index, mgmt_write, mgmt_read, mgmt_wdata} = '0;
end
// released index and write data lines show the inverse so stale values are never trusted
task automatic req(input logic s, input logic [4:0] i, input logic w,
                   input logic [15:0] d);
    @(posedge clk_sys);
    {mgmt_phy_sel, mgmt_index, mgmt_wdata} <= {s, i, d};
    {mgmt_write, mgmt_read} <= {w, !w};
    @(posedge clk_sys);
    {mgmt_write, mgmt_read} <= 2'b00;
    {mgmt_index, mgmt_wdata} <= ~{i, d};
endtask : req
task automatic rd(input logic s, input logic [4:0] i, output logic [15:0] q);
    req(s, i, 1'b0, 16'h0000);
    @(posedge clk_sys);
    #1 q = mgmt_rdata;
endtask : rd
task automatic set_mode(input logic s, input logic [2:0] m,
                        input logic [4:0] a);
    logic [15:0] cur;
    rd(s, 5'h12, cur);
    req(s, 5'h12, 1'b1, {cur[15:8], m, a});
endtask : set_mode
endmodule : mgmt_station
`default_nettype wire

// ### tb_top.sv
/* self-checking bench for phy_mode_special_regs with a station model
   assumes shortened quiet limits of 20 and 50 cycles */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
import phy_mode_special_pkg::*;
////////////////////////////////////////////////////////////////////////////
logic clk_sys = 1'b0;
logic srst, device_reset_control, mgmt_phy_sel, mgmt_write, mgmt_read;
logic [1:0] phy_soft_reset_bit, line_energy_seen, energy_detect_sleep;
logic [1:0] alternate_irq_select, line_energy_present, fiber_operation;
logic [1:0] speed_100, full_duplex, autoneg_enable, advertise_all;
logic [1:0] phy_power_down, carrier_on_transmit;
logic [1:0][4:0] phy_station_address;
logic [4:0] mgmt_index;
logic fiber_strap_first;
logic [4:0] address_strap_first;
logic [15:0] mgmt_wdata, mgmt_rdata, q;
int n_fail = 0;
int n_checks = 0;
// decode order: speed, duplex, autoneg, all, power down, carrier on tx
localparam logic [5:0] DEC [8] = '{6'h00, 6'h10, 6'h21, 6'h30,
                                   6'h38, 6'h00, 6'h02, 6'h0C};
always #4 clk_sys = ~clk_sys;
phy_mode_special_regs #(.QUIET_LIMIT(20), .QUIET_AN_LIMIT(50)) uut
(
    .clk_sys(clk_sys), .srst(srst), .device_reset_control(device_reset_control),
    .phy_soft_reset_bit(phy_soft_reset_bit),
    .fiber_strap_first(fiber_strap_first), .fiber_strap_second(1'b1),
    .address_strap_first(address_strap_first),
    .address_strap_second(5'h02), .line_energy_seen(line_energy_seen),
    .mgmt_phy_sel(mgmt_phy_sel), .mgmt_index(mgmt_index), .mgmt_read(mgmt_read),
    .mgmt_write(mgmt_write), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .energy_detect_sleep(energy_detect_sleep), .speed_100(speed_100),
    .alternate_irq_select(alternate_irq_select), .full_duplex(full_duplex),
    .line_energy_present(line_energy_present), .autoneg_enable(autoneg_enable),
    .fiber_operation(fiber_operation), .advertise_all(advertise_all),
    .phy_power_down(phy_power_down), .carrier_on_transmit(carrier_on_transmit),
    .phy_station_address(phy_station_address)
);
mgmt_station stn
(
    .clk_sys(clk_sys), .mgmt_rdata(mgmt_rdata), .mgmt_phy_sel(mgmt_phy_sel),
    .mgmt_index(mgmt_index), .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
    .mgmt_wdata(mgmt_wdata)
);
////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        n_fail++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
endtask : chk
task automatic pulse_soft();
    @(posedge clk_sys);
    phy_soft_reset_bit <= 2'b01;
    @(posedge clk_sys);
    phy_soft_reset_bit <= 2'b00;
endtask : pulse_soft
task automatic test_reset();
    stn.rd(1'b0, 5'h11, q); chk(q, 16'h0002);
    stn.rd(1'b0, 5'h12, q); chk(q, 16'h0081);
    stn.rd(1'b1, 5'h12, q); chk(q, 16'h0462);
    chk({6'h00, phy_station_address}, 16'h0041);
    stn.rd(1'b0, 5'h13, q); chk(q, 16'h0000);
    $display("test reset done");
endtask : test_reset
task automatic test_modes();
    for (int m = 0; m < 8; m++)
    begin
        stn.set_mode(1'b0, m[2:0], 5'h05);
        #1 chk({10'h000, speed_100[0], full_duplex[0], autoneg_enable[0],
                advertise_all[0], phy_power_down[0], carrier_on_transmit[0]},
               {10'h000, DEC[m]});
    end
    stn.req(1'b0, 5'h12, 1'b1, 16'hFFA5);
    stn.rd(1'b0, 5'h12, q); chk(q, 16'h00A5);
    stn.req(1'b0, 5'h11, 1'b1, 16'hFFFF);
    stn.rd(1'b0, 5'h11, q); chk(q, 16'h2042);
    $display("test modes done");
endtask : test_modes
task automatic test_soft();
    stn.set_mode(1'b0, 3'h2, 5'h07);
    @(posedge clk_sys);
    line_energy_seen <= 2'b10;
    repeat (60) @(posedge clk_sys);
    #1 chk({15'h0, line_energy_present[0]}, 16'h0000);
    stn.req(1'b0, 5'h11, 1'b1, 16'h2040);
    #1 chk({15'h0, energy_detect_sleep[0]}, 16'h0001);
    pulse_soft();
    stn.rd(1'b0, 5'h11, q); chk(q, 16'h0042);
    stn.rd(1'b0, 5'h12, q); chk(q, 16'h0047);
    @(posedge clk_sys);
    {device_reset_control, line_energy_seen} <= 3'b111;
    {fiber_strap_first, address_strap_first} <= 6'h23;
    @(posedge clk_sys);
    device_reset_control <= 1'b0;
    stn.rd(1'b0, 5'h11, q); chk(q, 16'h0002);
    stn.rd(1'b0, 5'h12, q); chk(q, 16'h0463);
    @(posedge clk_sys);
    line_energy_seen <= 2'b10;
    repeat (25) @(posedge clk_sys);
    pulse_soft();
    stn.rd(1'b0, 5'h11, q); chk(q, 16'h0000);
    @(posedge clk_sys);
    {fiber_strap_first, line_energy_seen} <= 3'b011;
    $display("test soft done");
endtask : test_soft
task automatic quiet_run(input int early, input int late);
    @(posedge clk_sys);
    line_energy_seen <= 2'b10;
    repeat (early) @(posedge clk_sys);
    #1 chk({14'h0, line_energy_present[0], energy_detect_sleep[0]},
           16'h0002);
    repeat (late) @(posedge clk_sys);
    #1 chk({14'h0, line_energy_present[0], energy_detect_sleep[0]},
           16'h0001);
    @(posedge clk_sys);
    line_energy_seen <= 2'b11;
endtask : quiet_run
task automatic test_energy();
    stn.req(1'b0, 5'h11, 1'b1, 16'h2000);
    stn.set_mode(1'b0, 3'h0, 5'h01);
    quiet_run(15, 10);
    stn.set_mode(1'b0, 3'h4, 5'h01);
    quiet_run(30, 25);
    $display("test energy done");
endtask : test_energy
task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask : give_verdict
initial
begin
    {srst, device_reset_control, phy_soft_reset_bit} = 4'b1000;
    {fiber_strap_first, address_strap_first} = 6'h01;
    line_energy_seen = 2'b11;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset();
    test_modes();
    test_soft();
    test_energy();
    give_verdict();
end
initial
begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
end
endmodule : tb_top
`default_nettype wire
